// [rtl/sln_pkg.sv]
// Package for the status LED and node setup block.
// Assumes a 100 MHz system clock; all times derive from it.
package sln_pkg;

  // Clock rate and millisecond tick
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned TICK_MS_CYC = CLK_HZ / 1000;

  // Blink phase times in ms
  localparam int unsigned T_50_MS = 50;
  localparam int unsigned T_200_MS = 200;
  localparam int unsigned T_500_MS = 500;
  localparam int unsigned T_1000_MS = 1000;

  // Setup timing in ms and min
  localparam int unsigned T_HOLD_MS = 3000;
  localparam int unsigned T_PAUSE_MS = 5000;
  localparam int unsigned T_STARTUP_MS = 1000;
  localparam int unsigned T_DISC_MIN = 20;
  localparam int unsigned T_DISC_MS = T_DISC_MIN * 60 * 1000;

  // Node number steps and limits
  localparam logic [6:0] NODE_TENS_STEP = 7'h0a;
  localparam logic [6:0] NODE_ONES_STEP = 7'h01;
  localparam logic [6:0] NODE_MAX = 7'h7f;

  // Contamination thresholds, percent efficiency loss
  localparam logic [6:0] WARN_PCT = 7'h28;
  localparam logic [6:0] ALARM_PCT = 7'h3c;

  // Drive limits: max frequency, duty bounds in percent
  localparam logic [6:0] HV_FMAX_HZ = 7'h64;
  localparam logic [6:0] DUTY_MIN_PCT = 7'h32;
  localparam logic [6:0] DUTY_MAX_PCT = 7'h5a;

  // Colour codes on the two LED dies
  typedef enum logic [1:0] {
    SLN_OFF = 2'b00,
    SLN_GRN = 2'b01,
    SLN_RED = 2'b10,
    SLN_YEL = 2'b11
  } sln_col_t;

  // Operating states
  typedef enum logic [3:0] {
    SLN_UNKNOWN = 4'h0,
    SLN_INIT = 4'h1,
    SLN_STANDBY = 4'h2,
    SLN_STOPPED = 4'h3,
    SLN_ACTIVE = 4'h4,
    SLN_DISCOVERY = 4'h5,
    SLN_WARN = 4'h6,
    SLN_ALARM = 4'h7,
    SLN_WORN = 4'h8,
    SLN_TIMEOUT = 4'h9,
    SLN_FAILURE = 4'ha,
    SLN_UNCONF = 4'hb,
    SLN_STARTUP = 4'hc,
    SLN_CHECK = 4'hd
  } sln_state_t;

  // Node setup entry phases
  typedef enum logic [1:0] {
    SLN_SET_IDLE = 2'b00,
    SLN_SET_TENS = 2'b01,
    SLN_SET_ONES = 2'b10
  } sln_set_t;

endpackage

// [rtl/sln_status.sv]
// Status LED, error return line, node number entry and drive settings.
// Assumes an external button pin and condition levels from the
// measurement logic on the same clock.
//
// Contract
// - Initializing flickers green 50/50 ms
// - Standby blinks green 500 on 1000 off
// - Warning alternates green and yellow 500 ms
// - Start-up blinks green 200/200 ms
// - Stopped flashes green 50 on 1000 off
// - Worn tips flicker red 50/50 ms
// - Unconfigured blinks red 200/200 ms
// - Check installation alternates red/yellow 50 ms
// - Error line high when healthy, low on fault
// - New node number applies after 3 s power loss; the code loads the stored number after any reset, with no 3 s check
// - Tens phase presses add ten
// - After 5 s pause presses add one
// - Pulse/pause ratio auto between 50 and 90
// - Warning at 40 percent efficiency loss
// - Alarm at 60 percent efficiency loss
// - Alternation frequency capped at 100 Hz
// - Start-up waits 1 s then initializes
// - Discovery ends after 20 minutes
`timescale 1ns/1ps

module sln_status
  import sln_pkg::*;
#(
  parameter int unsigned STARTUP_MS = T_STARTUP_MS,
  parameter int unsigned PAUSE_MS = T_PAUSE_MS,
  parameter int unsigned DISC_MS = T_DISC_MS,
  parameter int unsigned TICK_CYC = TICK_MS_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic button_n_in,
  input wire logic bus_seen_in,
  input wire logic master_stop_in,
  input wire logic master_run_in,
  input wire logic discovery_req_in,
  input wire logic init_done_in,
  input wire logic worn_tips_state_in,
  input wire logic sensor_lost_in,
  input wire logic fault_in,
  input wire logic near_ground_in,
  input wire logic [6:0] loss_pct_in,
  input wire logic [6:0] field_pct_in,
  input wire logic [6:0] stored_node_in,
  input wire logic [6:0] hv_freq_req_in,
  output logic led_green_out,
  output logic led_red_out,
  output logic error_line_out,
  output logic error_line_oe_out,
  output logic hv_enable_out,
  output logic [6:0] hv_duty_out,
  output logic [6:0] hv_freq_out,
  output logic [6:0] bus_node_number_out,
  output logic [6:0] pending_node_out,
  output logic node_save_out,
  output logic [3:0] state_out
);

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  logic [$clog2(TICK_CYC)-1:0] tick_cnt_q; // Cycle divider
  logic tick_ms; // One-cycle pulse per ms

  assign tick_ms = (tick_cnt_q == ($clog2(TICK_CYC))'(TICK_CYC - 1));

  // Free-running divider
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_q <= '0;
    end else if (tick_ms) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Button synchroniser, three stages
  logic [2:0] btn_sync_q; // Stage 0 only feeds stage 1
  logic btn_q; // Debounced pressed level
  logic press; // Press pulse

  // Shift the pin in, active low pressed
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      btn_sync_q <= 3'h0;
    end else begin
      btn_sync_q <= {btn_sync_q[1:0], ~button_n_in};
    end
  end

  // Accept a change once stages 1 and 2 agree
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      btn_q <= 1'b0;
    end else if (btn_sync_q[1] == btn_sync_q[2]) begin
      btn_q <= btn_sync_q[2];
    end
  end

  assign press = (btn_sync_q[1] == btn_sync_q[2]) && btn_sync_q[2] && !btn_q;

  ////////////////////////////////////////////////////////////////////////
  // Node number entry
  sln_set_t set_q; // Entry phase
  logic [12:0] pause_q; // Ms since last press or end of tens phase
  logic [6:0] node_acc_q; // Number being built
  logic [6:0] pend_q; // Saved, waits for power cycle

  // Saturating add, used by both phases
  function automatic logic [6:0] sat_add(input logic [6:0] a,
                                         input logic [6:0] b);
    logic [7:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[7] ? NODE_MAX : s[6:0];
  endfunction

  // Entry sequencer
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      set_q <= SLN_SET_IDLE;
      pause_q <= '0;
      node_acc_q <= '0;
      pend_q <= '0;
      node_save_out <= 1'b0;
    end else begin
      node_save_out <= 1'b0;
      if (press) begin
        pause_q <= '0;
      end else if (tick_ms && set_q != SLN_SET_IDLE) begin
        pause_q <= pause_q + 1'b1;
      end
      unique case (set_q)
        SLN_SET_IDLE: begin
          if (press) begin
            set_q <= SLN_SET_TENS;
            node_acc_q <= NODE_TENS_STEP;
          end
        end
        SLN_SET_TENS: begin
          if (press) begin
            node_acc_q <= sat_add(node_acc_q, NODE_TENS_STEP);
          end else if (pause_q >= 13'(PAUSE_MS)) begin
            set_q <= SLN_SET_ONES;
            pause_q <= '0;
          end
        end
        SLN_SET_ONES: begin
          if (press) begin
            node_acc_q <= sat_add(node_acc_q, NODE_ONES_STEP);
          end else if (pause_q >= 13'(PAUSE_MS)) begin
            set_q <= SLN_SET_IDLE;
            pend_q <= node_acc_q;
            node_save_out <= 1'b1;
          end
        end
        default: set_q <= SLN_SET_IDLE;
      endcase
    end
  end

  sln_state_t state_q; // Current operating state

  // Active number only from storage at power-up
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_node_number_out <= '0;
    end else if (state_q == SLN_UNKNOWN) begin
      bus_node_number_out <= stored_node_in;
    end
  end

  assign pending_node_out = pend_q;

  ////////////////////////////////////////////////////////////////////////
  // Operating state
  logic [20:0] st_ms_q; // Ms spent in state

  // State sequencer; faults take priority over conditions
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= SLN_UNKNOWN;
    end else begin
      unique case (state_q)
        SLN_UNKNOWN: begin
          state_q <= (stored_node_in == 7'h00) ? SLN_UNCONF : SLN_STARTUP;
        end
        SLN_UNCONF: begin
          // Held until a power cycle loads a stored number
          state_q <= SLN_UNCONF;
        end
        SLN_STARTUP: begin
          if (bus_seen_in) begin
            state_q <= SLN_STANDBY;
          end else if (st_ms_q >= 21'(STARTUP_MS)) begin
            state_q <= SLN_INIT;
          end
        end
        SLN_INIT: begin
          if (init_done_in) begin
            state_q <= SLN_ACTIVE;
          end
        end
        SLN_STANDBY, SLN_STOPPED: begin
          if (master_run_in) begin
            state_q <= SLN_INIT;
          end
        end
        SLN_DISCOVERY: begin
          if (st_ms_q >= 21'(DISC_MS)) begin
            state_q <= SLN_ACTIVE;
          end
        end
        default: begin
          // Running states, rechecked each cycle
          if (fault_in) begin
            state_q <= SLN_FAILURE;
          end else if (near_ground_in) begin
            state_q <= SLN_CHECK;
          end else if (master_stop_in) begin
            state_q <= SLN_STOPPED;
          end else if (discovery_req_in) begin
            state_q <= SLN_DISCOVERY;
          end else if (sensor_lost_in) begin
            state_q <= SLN_TIMEOUT;
          end else if (loss_pct_in >= ALARM_PCT) begin
            state_q <= SLN_ALARM;
          end else if (loss_pct_in >= WARN_PCT) begin
            state_q <= SLN_WARN;
          end else if (worn_tips_state_in) begin
            state_q <= SLN_WORN;
          end else begin
            state_q <= SLN_ACTIVE;
          end
        end
      endcase
    end
  end

  // Time in state, restarts on every change
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ms_q <= '0;
    end else if (state_out != state_q) begin
      st_ms_q <= '0;
    end else if (tick_ms && st_ms_q != '1) begin
      st_ms_q <= st_ms_q + 1'b1;
    end
  end

  // Previous state register for change detection
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_out <= 4'h0;
    end else begin
      state_out <= state_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Blink pattern
  logic [10:0] ph_q; // Ms within pattern period
  logic [10:0] period; // Pattern length
  logic [10:0] on_ms; // First phase length
  sln_col_t col_a; // First phase colour
  sln_col_t col_b; // Second phase colour
  sln_col_t col; // Shown colour

  // Pattern table per state
  always_comb begin
    on_ms = 11'(T_50_MS);
    period = 11'(2 * T_50_MS);
    col_a = SLN_OFF;
    col_b = SLN_OFF;
    unique case (state_q)
      SLN_INIT: begin
        col_a = SLN_GRN;
      end
      SLN_STANDBY: begin
        on_ms = 11'(T_500_MS);
        period = 11'(T_500_MS + T_1000_MS);
        col_a = SLN_GRN;
      end
      SLN_WARN: begin
        on_ms = 11'(T_500_MS);
        period = 11'(2 * T_500_MS);
        col_a = SLN_GRN;
        col_b = SLN_YEL;
      end
      SLN_STARTUP: begin
        on_ms = 11'(T_200_MS);
        period = 11'(2 * T_200_MS);
        col_a = SLN_GRN;
      end
      SLN_STOPPED: begin
        period = 11'(T_50_MS + T_1000_MS);
        col_a = SLN_GRN;
      end
      SLN_WORN: begin
        col_a = SLN_RED;
      end
      SLN_UNCONF: begin
        on_ms = 11'(T_200_MS);
        period = 11'(2 * T_200_MS);
        col_a = SLN_RED;
      end
      SLN_CHECK: begin
        col_a = SLN_RED;
        col_b = SLN_YEL;
      end
      SLN_ACTIVE, SLN_DISCOVERY, SLN_TIMEOUT: begin
        col_a = SLN_GRN;
        col_b = SLN_GRN;
      end
      SLN_ALARM: begin
        col_a = SLN_YEL;
        col_b = SLN_YEL;
      end
      SLN_FAILURE: begin
        col_a = SLN_RED;
        col_b = SLN_RED;
      end
      default: begin
        col_a = SLN_OFF;
      end
    endcase
  end

  // Phase counter, wraps at period
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_q <= '0;
    end else if (state_out != state_q) begin
      ph_q <= '0;
    end else if (tick_ms) begin
      ph_q <= (ph_q >= period - 11'h001) ? 11'h000 : ph_q + 11'h001;
    end
  end

  assign col = (ph_q < on_ms) ? col_a : col_b;

  // Registered LED drive
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_green_out <= 1'b0;
      led_red_out <= 1'b0;
    end else begin
      led_green_out <= col[0];
      led_red_out <= col[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error return line, open collector; external pull-up makes 24 V
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      error_line_oe_out <= 1'b1;
    end else begin
      error_line_oe_out <= (state_q == SLN_FAILURE) ||
                           (state_q == SLN_ALARM);
    end
  end

  assign error_line_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // High-voltage drive settings
  logic [7:0] duty_w; // Field-scaled duty before clamp

  assign duty_w = {1'b0, DUTY_MIN_PCT} + {2'b00, field_pct_in[6:1]};

  // Duty follows field, frequency follows request, both clamped
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hv_duty_out <= DUTY_MIN_PCT;
      hv_freq_out <= 7'h01;
      hv_enable_out <= 1'b0;
    end else begin
      hv_duty_out <= (duty_w > {1'b0, DUTY_MAX_PCT}) ? DUTY_MAX_PCT :
                     duty_w[6:0];
      hv_freq_out <= (hv_freq_req_in > HV_FMAX_HZ) ? HV_FMAX_HZ :
                     hv_freq_req_in;
      hv_enable_out <= (state_q == SLN_INIT) || (state_q == SLN_ACTIVE) ||
                       (state_q == SLN_WARN) || (state_q == SLN_ALARM) ||
                       (state_q == SLN_WORN) ||
                       (state_q == SLN_DISCOVERY);
    end
  end

endmodule

// [sim/sln_operator.sv]
// Operator button and node storage facing the status block.
// Assumes the block's clock; the button pin idles high when released.
`timescale 1ns/1ps

module sln_operator (
  input wire logic clk_sys_in,
  input wire logic node_save_in,
  input wire logic [6:0] pending_node_in,
  output logic button_n_out,
  output logic [6:0] stored_node_out
);
  // Released button, storage holding a configured number
  initial begin
    button_n_out = 1'b1;
    stored_node_out = 7'h05;
  end

  // Storage survives power cycles; the bench does the interruption
  always @(posedge clk_sys_in) begin
    if (node_save_in) begin
      stored_node_out <= pending_node_in;
    end
  end

  // Presses spaced well inside the pause window
  task automatic press(input int n);
    repeat (n) begin
      repeat (6) @(posedge clk_sys_in);
      #1 button_n_out = 1'b0;
      repeat (6) @(posedge clk_sys_in);
      #1 button_n_out = 1'b1;
    end
  endtask

  // Storage wiped, as after a lost configuration
  task automatic erase();
    stored_node_out = 7'h00;
  endtask
endmodule

// [sim/sln_status_checker.sv]
// Port checker for the status LED and node setup block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps

module sln_status_checker
  import sln_pkg::*;
#(
  parameter int unsigned STARTUP_MS = T_STARTUP_MS,
  parameter int unsigned TICK_CYC = TICK_MS_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic led_green_out,
  input wire logic led_red_out,
  input wire logic error_line_out,
  input wire logic error_line_oe_out,
  input wire logic [6:0] hv_duty_out,
  input wire logic [6:0] hv_freq_out,
  input wire logic node_save_out,
  input wire logic [3:0] state_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  ////////////////////////////////////////////////////////////////////////
  // Start-up dwell counter in cycles; a wait that never ends trips the bound below
  logic [15:0] su_cnt_q;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      su_cnt_q <= 16'h0000;
    end else if (state_out == SLN_STARTUP) begin
      su_cnt_q <= su_cnt_q + 16'h0001;
    end else begin
      su_cnt_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_startup_bound: assert property (
    su_cnt_q <= 16'((STARTUP_MS + 3) * TICK_CYC))
    else $error("start-up wait too long");
  a_err_drive_low: assert property (error_line_out == 1'b0)
    else $error("error line driven high");
  a_err_on_fail: assert property ((state_out == SLN_FAILURE)[*2]
    |-> error_line_oe_out) else $error("no pull in failure");
  a_err_on_alarm: assert property ((state_out == SLN_ALARM)[*2]
    |-> error_line_oe_out) else $error("no pull in alarm");
  a_err_healthy: assert property ((state_out == SLN_ACTIVE)[*2]
    |-> !error_line_oe_out) else $error("pull while healthy");
  a_duty_bound: assert property (
    hv_duty_out inside {[DUTY_MIN_PCT:DUTY_MAX_PCT]})
    else $error("duty out of range");
  a_freq_cap: assert property (hv_freq_out <= HV_FMAX_HZ)
    else $error("frequency above cap");
  a_active_green: assert property ((state_out == SLN_ACTIVE)[*2]
    |-> led_green_out && !led_red_out) else $error("active not green");
  a_alarm_yellow: assert property ((state_out == SLN_ALARM)[*2]
    |-> led_green_out && led_red_out) else $error("alarm not yellow");
  a_fail_red: assert property ((state_out == SLN_FAILURE)[*2]
    |-> !led_green_out && led_red_out) else $error("failure not red");
  a_unknown_dark: assert property (state_out == SLN_UNKNOWN
    |-> !led_green_out && !led_red_out) else $error("unknown lit");
  a_worn_no_green: assert property ((state_out == SLN_WORN)[*2]
    |-> !led_green_out) else $error("worn shows green");
  a_save_single: assert property (node_save_out |=> !node_save_out)
    else $error("save pulse too long");
endmodule

bind sln_status sln_status_checker #(
  .STARTUP_MS(STARTUP_MS),
  .TICK_CYC(TICK_CYC)
) u_chk (
  .clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in),
  .led_green_out(led_green_out),
  .led_red_out(led_red_out),
  .error_line_out(error_line_out),
  .error_line_oe_out(error_line_oe_out),
  .hv_duty_out(hv_duty_out),
  .hv_freq_out(hv_freq_out),
  .node_save_out(node_save_out),
  .state_out(state_out)
);

// [sim/testbench.sv]
// Self-checking bench for the status LED and node setup block.
// Assumes the operator model and the bound checker.
`timescale 1ns/1ps

module testbench;
  import sln_pkg::*;
  localparam int TK = 4; // Cycles per ms tick, shortened for run time
  logic clk_sys_in, rst_n_in, button_n_in, bus_seen_in, master_stop_in;
  logic master_run_in, discovery_req_in, init_done_in, worn_tips_state_in;
  logic sensor_lost_in, fault_in, near_ground_in, led_green_out;
  logic led_red_out, error_line_out, error_line_oe_out, hv_enable_out;
  logic node_save_out;
  logic [6:0] loss_pct_in, field_pct_in, stored_node_in, hv_freq_req_in;
  logic [6:0] hv_duty_out, hv_freq_out, bus_node_number_out;
  logic [6:0] pending_node_out;
  logic [3:0] state_out;
  int fails, samples_checked;

  sln_status #(.STARTUP_MS(1000), .PAUSE_MS(5), .DISC_MS(20),
    .TICK_CYC(TK)) dut (.clk_sys_in, .rst_n_in, .button_n_in,
    .bus_seen_in, .master_stop_in, .master_run_in, .discovery_req_in,
    .init_done_in, .worn_tips_state_in, .sensor_lost_in, .fault_in,
    .near_ground_in, .loss_pct_in, .field_pct_in, .stored_node_in,
    .hv_freq_req_in, .led_green_out, .led_red_out, .error_line_out,
    .error_line_oe_out, .hv_enable_out, .hv_duty_out, .hv_freq_out,
    .bus_node_number_out, .pending_node_out, .node_save_out, .state_out);
  sln_operator opr (.clk_sys_in, .node_save_in(node_save_out),
    .pending_node_in(pending_node_out), .button_n_out(button_n_in),
    .stored_node_out(stored_node_in));

  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Count in cycles against ms, 3 ms slack; ticks are not aligned to changes
  task automatic near_ms(input int got, input int ms);
    samples_checked++;
    if (got < (ms - 3) * TK || got > (ms + 3) * TK) begin
      fails++;
      $display("BAD %0t count %0d want %0d ms", $time, got, ms);
    end
  endtask

  // State check, then lit time of each die over a window
  task automatic see(input logic [3:0] s, input int w, input int gms,
    input int rms);
    int g, r;
    g = 0;
    r = 0;
    step(3);
    chk({3'h0, state_out}, {3'h0, s});
    repeat (w * TK) begin
      step(1);
      g += int'(led_green_out === 1'b1);
      r += int'(led_red_out === 1'b1);
    end
    near_ms(g, gms);
    near_ms(r, rms);
  endtask

  task automatic power(input logic bus);
    rst_n_in = 1'b0;
    bus_seen_in = bus;
    init_done_in = 1'b0;
    master_run_in = 1'b0;
    step(16);
    chk({5'h00, led_green_out, led_red_out}, 7'h00);
    chk({6'h00, error_line_oe_out}, 7'h01);
    chk(hv_duty_out, DUTY_MIN_PCT);
    rst_n_in = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_startup();
    int n;
    n = 0;
    see(4'hc, 800, 400, 0);
    while (state_out !== 4'h1 && n < 400 * TK) begin
      step(1);
      n++;
    end
    near_ms(n, 200);
    chk({6'h00, hv_enable_out}, 7'h01);
    see(4'h1, 1500, 750, 0);
    init_done_in = 1'b1;
    see(4'h4, 100, 100, 0);
    chk({6'h00, error_line_oe_out}, 7'h00);
    $display("end startup");
  endtask

  task automatic t_drive();
    field_pct_in = 7'h28;
    hv_freq_req_in = 7'h32;
    step(3);
    chk(hv_duty_out, 7'h46);
    chk(hv_freq_out, 7'h32);
    field_pct_in = 7'h64;
    hv_freq_req_in = 7'h78;
    step(3);
    chk(hv_duty_out, DUTY_MAX_PCT);
    chk(hv_freq_out, HV_FMAX_HZ);
    $display("end drive");
  endtask

  task automatic t_node();
    opr.press(3);
    // Long enough to close tens, short enough to keep ones open
    step(4 * TK);
    opr.press(2);
    step(7 * TK);
    chk(pending_node_out, 7'h20);
    chk(stored_node_in, 7'h20);
    chk(bus_node_number_out, 7'h05);
    $display("end node");
  endtask

  task automatic t_states();
    loss_pct_in = 7'h27;
    see(4'h4, 10, 10, 0);
    loss_pct_in = WARN_PCT;
    see(4'h6, 1500, 1500, 500);
    loss_pct_in = 7'h3b;
    see(4'h6, 10, 10, 10);
    loss_pct_in = ALARM_PCT;
    see(4'h7, 10, 10, 10);
    chk({6'h00, error_line_oe_out}, 7'h01);
    loss_pct_in = 7'h00;
    worn_tips_state_in = 1'b1;
    see(4'h8, 1500, 0, 750);
    worn_tips_state_in = 1'b0;
    fault_in = 1'b1;
    see(4'ha, 10, 0, 10);
    fault_in = 1'b0;
    near_ground_in = 1'b1;
    see(4'hd, 1500, 750, 1500);
    near_ground_in = 1'b0;
    sensor_lost_in = 1'b1;
    see(4'h9, 10, 10, 0);
    sensor_lost_in = 1'b0;
    discovery_req_in = 1'b1;
    see(4'h5, 12, 12, 0);
    discovery_req_in = 1'b0;
    // Let the discovery dwell run out before looking again
    step(12 * TK);
    see(4'h4, 10, 10, 0);
    master_stop_in = 1'b1;
    see(4'h3, 1500, 100, 0);
    master_stop_in = 1'b0;
    master_run_in = 1'b1;
    see(4'h4, 10, 10, 0);
    $display("end states");
  endtask

  task automatic t_restart();
    power(1'b1);
    see(4'h2, 1500, 500, 0);
    chk(bus_node_number_out, 7'h20);
    opr.erase();
    power(1'b0);
    see(4'hb, 1500, 0, 800);
    $display("end restart");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #(70000 * 10);
    fails++;
    test_done();
  end

  initial begin
    fails = 0;
    samples_checked = 0;
    {rst_n_in, bus_seen_in, master_stop_in, master_run_in} = 4'h0;
    {discovery_req_in, init_done_in, worn_tips_state_in} = 3'h0;
    {sensor_lost_in, fault_in, near_ground_in} = 3'h0;
    loss_pct_in = 7'h00;
    field_pct_in = 7'h00;
    hv_freq_req_in = 7'h14;
    power(1'b0);
    t_startup();
    t_drive();
    t_node();
    t_states();
    t_restart();
    test_done();
  end
endmodule
